// ---- rtmc_pkg.sv ----
// Constants shared by the resistive touch mode controller.
package rtmc_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_FIFO = 8'h0C;
  localparam logic [7:0] OFS_SETTLE = 8'h10;
  localparam logic [7:0] OFS_APERTURE_FILTER = 8'h14;
  localparam logic [3:0] OFS_RES_HI = 4'h2;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_CONTINUOUS_CONVERSION = 1;
  localparam int CTRL_MED = 2;
  localparam int CTRL_AVG = 3;
  localparam int CTRL_LPM = 4;
  localparam int CTRL_APERTURE_FILTER = 5;
  localparam int CTRL_IRQ = 6;
  localparam int CTRL_SCAN = 8;
  localparam int CMD_OP = 0;
  localparam int CMD_KIND = 4;
  localparam int STAT_IRQ = 3;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] SETTLE_RST = 16'h0010;
  localparam logic [11:0] APERTURE_FILTER_RST = 12'h010;
  localparam logic [1:0] OP_STOP = 2'h0;
  localparam logic [1:0] OP_SINGLE = 2'h1;
  localparam logic [1:0] OP_COMB = 2'h2;
  localparam logic [1:0] IRQ_EVENT = 2'h0;
  localparam logic [1:0] IRQ_CONTINUOUS_CONVERSION = 2'h1;
  localparam logic [1:0] IRQ_FIFO = 2'h2;
  localparam logic [1:0] EVENT_TAG_PRESENT = 2'h0;
  localparam logic [1:0] EVENT_TAG_NONE = 2'h2;
  localparam logic [1:0] EVENT_TAG_BUSY = 2'h3;
  localparam logic [1:0] EV_INIT = 2'h0;
  localparam logic [1:0] EV_CONTINUOUS_CONVERSION = 2'h1;
  localparam logic [1:0] EV_REL = 2'h2;
  typedef enum logic [2:0] {K_X, K_Y, K_Z1, K_Z2, K_AUX, K_DET} rtmc_kind_type;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 200;
  localparam int CHECK_NS = 1000;
  localparam int CHECK_CYC = (CHECK_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- rtmc_top.sv ----
// Mode, scan sequencing, filtering, tagging and result FIFO of the touch controller.
`timescale 1ns/10ps
`default_nettype none
module rtmc_top #(
  parameter int FIFO_DEPTH = rtmc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic lclk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic touch_sense,
  input wire logic adc_valid,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [2:0] meas_sel,
  output logic panel_low_power,
  output logic touch_irq_n
);
  localparam int PW = $clog2(FIFO_DEPTH);
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_REQ, S_WAIT, S_NEXT, S_CHECK, S_TAG} rtmc_state_type;
  rtmc_state_type st_q, st_d;
  logic [9:0] ctrl_q, ctrl_d;
  logic [15:0] settle_q, settle_d, cnt_q, cnt_d;
  logic [11:0] aperture_filter_q, aperture_filter_d, lx_q, lx_d, ly_q, ly_d, max_q, max_d, min_q, min_d, filt;
  logic [1:0] op_q, op_d, nsmp_q, nsmp_d, kidx_q, kidx_d, tagi_q, tagi_d, event_tag_q, event_tag_d, ev_q, ev_d;
  logic [2:0] ckind_q, ckind_d, nk_q, nk_d, meas_q, meas_d, nks;
  logic [13:0] sum_q, sum_d, mid;
  logic [11:0] buf_q [4];
  logic [11:0] buf_d [4];
  logic [17:0] mem_q [FIFO_DEPTH];
  logic [17:0] mem_d [FIFO_DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] fc_q, fc_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0] aa_q, aa_d;
  logic aw_q, aw_d, irqn_q, irqn_d, touched_q, touched_d, lp_q, lp_d, skip_q, skip_d, req_q, req_d;
  logic t1_q, t2_q, a1_q, a2_q, a3_q, push, pop, start, auto_m, continuous_conversion_e, lp_e, aperture_filter_e, avg_e;
  logic [1:0] irqm_e;
  logic r1_q, r2_q, r3_q, start_q, start_d, ack_q, ack_d;
  logic [11:0] hold_q, hold_d;

  // Measurement kind of a sequence step; a single command uses its own kind.
  function automatic rtmc_pkg::rtmc_kind_type kind_of(input logic [1:0] i, input logic [2:0] n,
                                                      input logic [2:0] k);
    return n == 3'h1 ? rtmc_pkg::rtmc_kind_type'(k) : rtmc_pkg::rtmc_kind_type'({1'b0, i});
  endfunction

  // True when two positions lie within the aperture window of each other.
  function automatic logic near(input logic [11:0] a, input logic [11:0] b, input logic [11:0] t);
    return (a > b ? a - b : b - a) <= t;
  endfunction

  // Options are forced off outside the mode that allows them.
  assign auto_m = ctrl_q[rtmc_pkg::CTRL_MODE];
  assign continuous_conversion_e = !auto_m && ctrl_q[rtmc_pkg::CTRL_CONTINUOUS_CONVERSION];
  assign lp_e = auto_m && ctrl_q[rtmc_pkg::CTRL_LPM];
  assign aperture_filter_e = auto_m && ctrl_q[rtmc_pkg::CTRL_APERTURE_FILTER];
  assign avg_e = ctrl_q[rtmc_pkg::CTRL_AVG];
  assign irqm_e = auto_m ? rtmc_pkg::IRQ_FIFO :
                  (ctrl_q[rtmc_pkg::CTRL_IRQ+:2] == rtmc_pkg::IRQ_FIFO ? rtmc_pkg::IRQ_EVENT :
                   ctrl_q[rtmc_pkg::CTRL_IRQ+:2]);
  assign nks = ctrl_q[rtmc_pkg::CTRL_SCAN+:2] == 2'h0 ? 3'h2 :
               ctrl_q[rtmc_pkg::CTRL_SCAN+:2] == 2'h1 ? 3'h3 : 3'h4;
  // Median of four drops the extremes and halves the middle pair.
  assign mid = sum_q - {2'h0, max_q} - {2'h0, min_q};
  assign filt = !avg_e ? sum_q[11:0] : ctrl_q[rtmc_pkg::CTRL_MED] ? mid[12:1] : sum_q[13:2];

  // Bus slave, command intake, sequencer and FIFO next values.
  always_comb begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    settle_d = settle_q;
    aperture_filter_d = aperture_filter_q;
    cnt_d = cnt_q;
    op_d = op_q;
    ckind_d = ckind_q;
    nk_d = nk_q;
    kidx_d = kidx_q;
    nsmp_d = nsmp_q;
    tagi_d = tagi_q;
    event_tag_d = event_tag_q;
    ev_d = ev_q;
    meas_d = meas_q;
    sum_d = sum_q;
    max_d = max_q;
    min_d = min_q;
    lx_d = lx_q;
    ly_d = ly_q;
    buf_d = buf_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    irqn_d = irqn_q;
    touched_d = touched_q;
    lp_d = lp_q;
    skip_d = skip_q;
    req_d = req_q;
    rd_d = rd_q;
    push = 1'b0;
    pop = 1'b0;
    start = 1'b0;
    aw_d = hsel && hready && htrans[1] && hwrite && haddr[31:8] == 24'h0;
    aa_d = haddr[7:0];
    // Reads are answered from the address phase; a FIFO read pops one entry unless the FIFO is empty.
    if (hsel && hready && htrans[1] && !hwrite) begin
      rd_d = 32'h0;
      if (haddr[31:8] == 24'h0) begin
        if (haddr[7:4] == rtmc_pkg::OFS_RES_HI) begin
          rd_d = {14'h0, event_tag_q, 1'b0, kind_of(haddr[3:2], nk_q, ckind_q), buf_q[haddr[3:2]]};
        end else if (haddr[7:0] == rtmc_pkg::OFS_CTRL) begin
          rd_d = {22'h0, ctrl_q};
        end else if (haddr[7:0] == rtmc_pkg::OFS_SETTLE) begin
          rd_d = {16'h0, settle_q};
        end else if (haddr[7:0] == rtmc_pkg::OFS_APERTURE_FILTER) begin
          rd_d = {20'h0, aperture_filter_q};
        end else if (haddr[7:0] == rtmc_pkg::OFS_STAT) begin
          rd_d = {23'h0, 5'(fc_q), ~irqn_q, st_q != S_IDLE, event_tag_q};
        end else if (haddr[7:0] == rtmc_pkg::OFS_FIFO && fc_q != '0) begin
          rd_d = {14'h0, mem_q[rp_q]};
          pop = 1'b1;
          rp_d = rp_q + 1'b1;
        end
      end
    end
    // Writes land in the data phase.
    if (aw_q) begin
      if (aa_q == rtmc_pkg::OFS_CTRL) begin
        ctrl_d = hwdata[9:0];
      end else if (aa_q == rtmc_pkg::OFS_SETTLE) begin
        settle_d = hwdata[15:0];
      end else if (aa_q == rtmc_pkg::OFS_APERTURE_FILTER) begin
        aperture_filter_d = hwdata[11:0];
      end else if (aa_q == rtmc_pkg::OFS_STAT && hwdata[rtmc_pkg::STAT_IRQ]) begin
        irqn_d = 1'b1;
      end else if (aa_q == rtmc_pkg::OFS_CMD) begin
        // A new command is taken only while nothing else runs; stop is always taken.
        if (hwdata[rtmc_pkg::CMD_OP+:2] == rtmc_pkg::OP_STOP) begin
          op_d = rtmc_pkg::OP_STOP;
        end else if (st_q == S_IDLE && op_q == rtmc_pkg::OP_STOP) begin
          if (hwdata[rtmc_pkg::CMD_OP+:2] == rtmc_pkg::OP_COMB) begin
            op_d = rtmc_pkg::OP_COMB;
          end else if (!auto_m && hwdata[rtmc_pkg::CMD_OP+:2] == rtmc_pkg::OP_SINGLE &&
                       hwdata[rtmc_pkg::CMD_KIND+:3] <= 3'(rtmc_pkg::K_AUX)) begin
            op_d = rtmc_pkg::OP_SINGLE;
            ckind_d = hwdata[rtmc_pkg::CMD_KIND+:3];
          end
        end
      end
    end
    // Sequencer.
    unique case (st_q)
      S_IDLE: begin
        lp_d = lp_e;
        if (!auto_m) begin
          touched_d = t2_q;
          if (irqm_e == rtmc_pkg::IRQ_EVENT && t2_q && !touched_q) begin
            irqn_d = 1'b0;
          end
          start = op_q != rtmc_pkg::OP_STOP;
        end else begin
          start = t2_q || touched_q || op_q == rtmc_pkg::OP_COMB;
        end
        if (start) begin
          st_d = S_SETTLE;
          kidx_d = 2'h0;
          nsmp_d = 2'h0;
          cnt_d = settle_q;
          lp_d = 1'b0;
          nk_d = (!auto_m && op_q == rtmc_pkg::OP_SINGLE) ? 3'h1 : nks;
          meas_d = (!auto_m && op_q == rtmc_pkg::OP_SINGLE) ? ckind_q : 3'(rtmc_pkg::K_X);
          if (auto_m) begin
            op_d = rtmc_pkg::OP_STOP;
          end else begin
            event_tag_d = rtmc_pkg::EVENT_TAG_BUSY;
          end
        end
      end
      S_SETTLE: begin
        if (cnt_q == 16'h0) begin
          st_d = S_REQ;
        end else begin
          cnt_d = cnt_q - 16'h1;
        end
      end
      S_REQ: begin
        req_d = ~req_q;
        st_d = S_WAIT;
      end
      S_WAIT: begin
        if (a2_q ^ a3_q) begin
          sum_d = (nsmp_q == 2'h0 ? 14'h0 : sum_q) + {2'h0, hold_q};
          max_d = (nsmp_q == 2'h0 || hold_q > max_q) ? hold_q : max_q;
          min_d = (nsmp_q == 2'h0 || hold_q < min_q) ? hold_q : min_q;
          if (!avg_e || nsmp_q == 2'h3) begin
            nsmp_d = 2'h0;
            st_d = S_NEXT;
          end else begin
            nsmp_d = nsmp_q + 2'h1;
            st_d = S_REQ;
          end
        end
      end
      S_NEXT: begin
        buf_d[kidx_q] = filt;
        if (kidx_q == 2'(nk_q - 3'h1)) begin
          if (continuous_conversion_e) begin
            event_tag_d = rtmc_pkg::EVENT_TAG_PRESENT;
            st_d = S_IDLE;
            if (irqm_e == rtmc_pkg::IRQ_CONTINUOUS_CONVERSION) begin
              irqn_d = 1'b0;
            end
          end else begin
            st_d = S_CHECK;
            cnt_d = 16'(rtmc_pkg::CHECK_CYC);
            meas_d = 3'(rtmc_pkg::K_DET);
          end
        end else begin
          kidx_d = kidx_q + 2'h1;
          meas_d = kind_of(kidx_q + 2'h1, nk_q, ckind_q);
          cnt_d = settle_q;
          st_d = S_SETTLE;
        end
      end
      S_CHECK: begin
        if (cnt_q != 16'h0) begin
          cnt_d = cnt_q - 16'h1;
        end else if (!auto_m) begin
          event_tag_d = t2_q ? rtmc_pkg::EVENT_TAG_PRESENT : rtmc_pkg::EVENT_TAG_NONE;
          st_d = S_IDLE;
          if (!continuous_conversion_e) begin
            op_d = rtmc_pkg::OP_STOP;
          end
          if (irqm_e == rtmc_pkg::IRQ_CONTINUOUS_CONVERSION) begin
            irqn_d = 1'b0;
          end
        end else begin
          ev_d = t2_q ? (touched_q ? rtmc_pkg::EV_CONTINUOUS_CONVERSION : rtmc_pkg::EV_INIT) : rtmc_pkg::EV_REL;
          skip_d = aperture_filter_e && t2_q && touched_q && near(buf_q[0], lx_q, aperture_filter_q) &&
                   near(buf_q[1], ly_q, aperture_filter_q);
          touched_d = t2_q;
          tagi_d = 2'h0;
          st_d = S_TAG;
        end
      end
      S_TAG: begin
        // A full FIFO stalls the scanner until the host drains it.
        if (skip_q) begin
          st_d = S_IDLE;
        end else if (fc_q != (PW+1)'(FIFO_DEPTH)) begin
          push = 1'b1;
          mem_d[wp_q] = {ev_q, 1'b0, kind_of(tagi_q, nk_q, ckind_q), buf_q[tagi_q]};
          wp_d = wp_q + 1'b1;
          tagi_d = tagi_q + 2'h1;
          if (tagi_q == 2'(nk_q - 3'h1)) begin
            st_d = S_IDLE;
            lx_d = buf_q[0];
            ly_d = buf_q[1];
            irqn_d = 1'b0;
          end
        end
      end
    endcase
    fc_d = fc_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Bus-side registers, synchronisers and sequencer state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      ctrl_q <= rtmc_pkg::CTRL_RST;
      settle_q <= rtmc_pkg::SETTLE_RST;
      aperture_filter_q <= rtmc_pkg::APERTURE_FILTER_RST;
      cnt_q <= 16'h0;
      op_q <= rtmc_pkg::OP_STOP;
      ckind_q <= 3'h0;
      nk_q <= 3'h1;
      kidx_q <= 2'h0;
      nsmp_q <= 2'h0;
      tagi_q <= 2'h0;
      event_tag_q <= rtmc_pkg::EVENT_TAG_NONE;
      ev_q <= rtmc_pkg::EV_INIT;
      meas_q <= 3'(rtmc_pkg::K_DET);
      sum_q <= 14'h0;
      max_q <= 12'h0;
      min_q <= 12'h0;
      lx_q <= 12'h0;
      ly_q <= 12'h0;
      buf_q <= '{default: 12'h0};
      mem_q <= '{default: 18'h0};
      wp_q <= '0;
      rp_q <= '0;
      fc_q <= '0;
      irqn_q <= 1'b1;
      touched_q <= 1'b0;
      lp_q <= 1'b0;
      skip_q <= 1'b0;
      req_q <= 1'b0;
      rd_q <= 32'h0;
      aw_q <= 1'b0;
      aa_q <= 8'h0;
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      a1_q <= 1'b0;
      a2_q <= 1'b0;
      a3_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      settle_q <= settle_d;
      aperture_filter_q <= aperture_filter_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      ckind_q <= ckind_d;
      nk_q <= nk_d;
      kidx_q <= kidx_d;
      nsmp_q <= nsmp_d;
      tagi_q <= tagi_d;
      event_tag_q <= event_tag_d;
      ev_q <= ev_d;
      meas_q <= meas_d;
      sum_q <= sum_d;
      max_q <= max_d;
      min_q <= min_d;
      lx_q <= lx_d;
      ly_q <= ly_d;
      buf_q <= buf_d;
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      fc_q <= fc_d;
      irqn_q <= irqn_d;
      touched_q <= touched_d;
      lp_q <= lp_d;
      skip_q <= skip_d;
      req_q <= req_d;
      rd_q <= rd_d;
      aw_q <= aw_d;
      aa_q <= aa_d;
      t1_q <= touch_sense;
      t2_q <= t1_q;
      a1_q <= ack_q;
      a2_q <= a1_q;
      a3_q <= a2_q;
    end
  end

  // Link side: the request toggle becomes a start pulse, a result toggles back.
  always_comb begin
    start_d = r2_q ^ r3_q;
    hold_d = adc_valid ? adc_data : hold_q;
    ack_d = ack_q ^ adc_valid;
  end

  // Held result stays stable until the next request, so the bus side may sample it.
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      r1_q <= 1'b0;
      r2_q <= 1'b0;
      r3_q <= 1'b0;
      start_q <= 1'b0;
      hold_q <= 12'h0;
      ack_q <= 1'b0;
    end else begin
      r1_q <= req_q;
      r2_q <= r1_q;
      r3_q <= r2_q;
      start_q <= start_d;
      hold_q <= hold_d;
      ack_q <= ack_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign adc_start = start_q;
  assign meas_sel = meas_q;
  assign panel_low_power = lp_q;
  assign touch_irq_n = irqn_q;

  property p_fifo_cap;
    @(posedge clk) disable iff (!nrst) fc_q <= (PW+1)'(FIFO_DEPTH);
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("FIFO count above depth");
  property p_direct_idle;
    @(posedge clk) disable iff (!nrst)
      (ce && st_q == S_IDLE && !auto_m && op_q == rtmc_pkg::OP_STOP) |=> st_q == S_IDLE;
  endproperty
  a_direct_idle: assert property (p_direct_idle) else $error("Direct mode ran without command");
  property p_comb_len;
    @(posedge clk) disable iff (!nrst)
      (ce && !aw_q && st_q == S_IDLE && op_q == rtmc_pkg::OP_COMB) |=> (st_q == S_SETTLE && nk_q == $past(nks));
  endproperty
  a_comb_len: assert property (p_comb_len) else $error("Combined command length wrong");
  property p_one_sample;
    @(posedge clk) disable iff (!nrst)
      (ce && st_q == S_WAIT && (a2_q ^ a3_q) && !avg_e) |=> st_q == S_NEXT;
  endproperty
  a_one_sample: assert property (p_one_sample) else $error("Unaveraged step took extra samples");
  property p_direct_nofifo;
    @(posedge clk) disable iff (!nrst) (ce && !auto_m) |=> fc_q <= $past(fc_q);
  endproperty
  a_direct_nofifo: assert property (p_direct_nofifo) else $error("FIFO filled in direct mode");
  property p_scan_len;
    @(posedge clk) disable iff (!nrst) (st_q == S_TAG) |-> (nk_q >= 3'h2 && nk_q <= 3'h4);
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("Scan set outside allowed range");
  property p_busy_tag;
    @(posedge clk) disable iff (!nrst)
      (!auto_m && st_q inside {S_SETTLE, S_REQ, S_WAIT, S_NEXT}) |-> event_tag_q == rtmc_pkg::EVENT_TAG_BUSY;
  endproperty
  a_busy_tag: assert property (p_busy_tag) else $error("Busy tag missing");
  property p_touch_irq;
    @(posedge clk) disable iff (!nrst)
      (ce && st_q == S_IDLE && irqm_e == rtmc_pkg::IRQ_EVENT && t2_q && !touched_q) |=> !touch_irq_n;
  endproperty
  a_touch_irq: assert property (p_touch_irq) else $error("Touch did not raise interrupt");
  property p_check_det;
    @(posedge clk) disable iff (!nrst) (st_q == S_CHECK && $past(st_q) == S_CHECK) |-> meas_sel == 3'h5;
  endproperty
  a_check_det: assert property (p_check_det) else $error("Touch check without detect setup");
  property p_start_pulse;
    @(posedge lclk) disable iff (!nrst) adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("Start pulse too long");
endmodule
`default_nettype wire

// ---- rtmc_adc_model.sv ----
// Behavioural converter on the link clock that answers each start with one sample.
`timescale 1ns/10ps
`default_nettype none
module rtmc_adc_model (
  input wire logic lclk,
  input wire logic nrst,
  input wire logic adc_start,
  input wire logic [2:0] meas_sel,
  input wire logic spread,
  input wire logic slow,
  output logic adc_valid,
  output logic [11:0] adc_data
);
  logic [2:0] kind_q;
  logic [3:0] wait_q;
  logic pend_q;
  logic [1:0] cnt_q;

  // One conversion at a time; between answers the data lines toggle so a stale value never looks valid.
  // With spread set, every fourth sample is 8 codes high, so mean and median of any four differ.
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      kind_q <= 3'h0;
      wait_q <= 4'h0;
      pend_q <= 1'b0;
      cnt_q <= 2'h0;
      adc_valid <= 1'b0;
      adc_data <= 12'h000;
    end else if (adc_start) begin
      kind_q <= meas_sel;
      wait_q <= slow ? 4'h6 : 4'h1;
      pend_q <= 1'b1;
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
    end else if (pend_q && wait_q == 4'h0) begin
      adc_valid <= 1'b1;
      adc_data <= {1'b0, kind_q, 8'h23} + 12'h100 + ((spread && cnt_q == 2'h3) ? 12'h008 : 12'h000);
      cnt_q <= cnt_q + 2'h1;
      pend_q <= 1'b0;
    end else begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      wait_q <= pend_q ? wait_q - 4'h1 : wait_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtmc_top_tb.sv ----
// Self-checking bench for the touch mode controller with its converter model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module rtmc_top_tb;
  logic clk, nrst, ce, lclk, hsel, hwrite, touch_sense, spread, slow;
  logic hreadyout, hresp, adc_start, adc_valid, panel_low_power, touch_irq_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, last_ev;
  logic [2:0] hsize, meas_sel;
  logic [11:0] adc_data;
  int errors, checks, cycles;

  rtmc_top u_rtmc_top (.clk(clk), .nrst(nrst), .ce(ce), .lclk(lclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .touch_sense(touch_sense),
    .adc_valid(adc_valid), .adc_data(adc_data), .adc_start(adc_start), .meas_sel(meas_sel),
    .panel_low_power(panel_low_power), .touch_irq_n(touch_irq_n));
  rtmc_adc_model u_rtmc_adc_model (.lclk(lclk), .nrst(nrst), .adc_start(adc_start), .meas_sel(meas_sel),
    .spread(spread), .slow(slow), .adc_valid(adc_valid), .adc_data(adc_data));

  // Bus clock and an unrelated link clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7.3;
    forever #15 lclk = ~lclk;
  end

  // A hang would leave the verdict unprinted, so the cycle ceiling forces it.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One single AHB-Lite transfer; read data lands in rd at the closing edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Polls the busy flag under a bound.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    do begin
      bus(1'b0, rtmc_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 5000);
    `CHK(rd[2], 1'b0)
  endtask

  function automatic logic [11:0] base(input logic [2:0] k);
    return {1'b0, k, 8'h23} + 12'h100;
  endfunction

  task automatic t_reset();
    bus(1'b0, rtmc_pkg::OFS_CTRL, 32'h0);
    `CHK(rd, 32'h00000000)
    bus(1'b0, rtmc_pkg::OFS_SETTLE, 32'h0);
    `CHK(rd, 32'h00000010)
    bus(1'b0, rtmc_pkg::OFS_APERTURE_FILTER, 32'h0);
    `CHK(rd, 32'h00000010)
    bus(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(hresp, 1'b0)
  endtask

  task automatic t_irq();
    int n;
    touch_sense <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (touch_irq_n !== 1'b0 && n < 50);
    `CHK(touch_irq_n, 1'b0)
    bus(1'b0, rtmc_pkg::OFS_STAT, 32'h0);
    `CHK(rd[3], 1'b1)
    bus(1'b1, rtmc_pkg::OFS_STAT, 32'h00000008);
    repeat (3) @(posedge clk);
    `CHK(touch_irq_n, 1'b1)
  endtask

  // Each single kind, slow and prompt answers, then one without a touch.
  task automatic t_single();
    for (int k = 0; k < 6; k++) begin
      slow <= k[0];
      touch_sense <= (k < 5);
      bus(1'b1, rtmc_pkg::OFS_CMD, {25'h0, k[2:0] % 3'h5, 4'h1});
      wait_idle();
      bus(1'b0, 8'h20, 32'h0);
      `CHK(rd[17:0], {(k < 5) ? rtmc_pkg::EVENT_TAG_PRESENT : rtmc_pkg::EVENT_TAG_NONE, 1'b0, k[2:0] % 3'h5, base(k[2:0] % 3'h5)})
    end
    touch_sense <= 1'b1;
  endtask

  task automatic t_avg();
    spread <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, rtmc_pkg::OFS_CTRL, (32'h1 << rtmc_pkg::CTRL_AVG) | (m << rtmc_pkg::CTRL_MED));
      bus(1'b1, rtmc_pkg::OFS_CMD, 32'h00000011);
      wait_idle();
      bus(1'b0, 8'h20, 32'h0);
      `CHK(rd[11:0], base(3'h1) + (m ? 12'h000 : 12'h002))
    end
    spread <= 1'b0;
  endtask

  task automatic t_comb();
    bus(1'b1, rtmc_pkg::OFS_SETTLE, 32'h00000020);
    bus(1'b1, rtmc_pkg::OFS_CTRL, 32'h2 << rtmc_pkg::CTRL_SCAN);
    bus(1'b1, rtmc_pkg::OFS_CMD, {30'h0, rtmc_pkg::OP_COMB});
    wait_idle();
    for (int s = 0; s < 4; s++) begin
      bus(1'b0, 8'h20 + 8'(4 * s), 32'h0);
      `CHK(rd[14:0], {s[2:0], base(s[2:0])})
    end
  endtask

  // Continuous conversion without touch never reports the no-touch code.
  task automatic t_continuous_conversion();
    touch_sense <= 1'b0;
    bus(1'b1, rtmc_pkg::OFS_CTRL, (32'h1 << rtmc_pkg::CTRL_CONTINUOUS_CONVERSION) | (32'h1 << rtmc_pkg::CTRL_LPM) |
        (32'h1 << rtmc_pkg::CTRL_IRQ));
    bus(1'b1, rtmc_pkg::OFS_STAT, 32'h00000008);
    bus(1'b1, rtmc_pkg::OFS_CMD, 32'h00000001);
    `CHK(panel_low_power, 1'b0)
    repeat (20) begin
      bus(1'b0, rtmc_pkg::OFS_STAT, 32'h0);
      `CHK(rd[1:0] == rtmc_pkg::EVENT_TAG_NONE, 1'b0)
    end
    bus(1'b1, rtmc_pkg::OFS_CMD, {30'h0, rtmc_pkg::OP_STOP});
    wait_idle();
    `CHK(touch_irq_n, 1'b0)
  endtask

  // A frozen enable drops a write; a reset applied between runs restores the defaults.
  task automatic t_hold();
    ce <= 1'b0;
    bus(1'b1, rtmc_pkg::OFS_CTRL, 32'h1);
    ce <= 1'b1;
    bus(1'b0, rtmc_pkg::OFS_CTRL, 32'h0);
    `CHK(rd, 32'h00000052)
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, rtmc_pkg::OFS_CTRL, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(touch_irq_n, 1'b1)
  endtask

  // Self-timed scans fill the FIFO to its depth, stall, then tag the release.
  task automatic t_auto();
    int n;
    bus(1'b1, rtmc_pkg::OFS_CTRL, 32'h1 | (32'h1 << rtmc_pkg::CTRL_LPM) | (32'h2 << rtmc_pkg::CTRL_IRQ));
    bus(1'b1, rtmc_pkg::OFS_STAT, 32'h00000008);
    bus(1'b1, rtmc_pkg::OFS_CMD, 32'h00000001);
    repeat (20) @(posedge clk);
    `CHK(panel_low_power, 1'b1)
    `CHK(touch_irq_n, 1'b1)
    touch_sense <= 1'b1;
    n = 0;
    do begin
      bus(1'b0, rtmc_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd[8:4] !== 5'h10 && n < 8000);
    `CHK(touch_irq_n, 1'b0)
    repeat (600) @(posedge clk);
    bus(1'b0, rtmc_pkg::OFS_STAT, 32'h0);
    `CHK(rd[8:4], 5'h10)
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, rtmc_pkg::OFS_FIFO, 32'h0);
      if (i < 3)
        `CHK(rd[17:0], {(i < 2) ? rtmc_pkg::EV_INIT : rtmc_pkg::EV_CONTINUOUS_CONVERSION, 1'b0, 2'h0, i[0], base({2'h0, i[0]})})
    end
    touch_sense <= 1'b0;
    repeat (3000) @(posedge clk);
    last_ev = 2'h3;
    n = 0;
    do begin
      bus(1'b0, rtmc_pkg::OFS_FIFO, 32'h0);
      last_ev = (rd !== 32'h0) ? rd[17:16] : last_ev;
      n++;
    end while (rd !== 32'h0 && n < 20);
    `CHK(last_ev, rtmc_pkg::EV_REL)
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    touch_sense = 1'b0;
    spread = 1'b0;
    slow = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    `CHK(touch_irq_n, 1'b1)
    `CHK(hrdata, 32'h00000000)
    `CHK(meas_sel, 3'h5)
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_irq();
    t_single();
    t_avg();
    t_comb();
    t_continuous_conversion();
    t_hold();
    t_auto();
    report_and_stop();
  end
endmodule
`default_nettype wire
